// *** dv/crf_formatter_sva.sv ***
// checker for the card reader input formatter top ports
// assumes one clock domain; bound into the top module below
`timescale 1ns/10ps
`default_nettype none
module crf_formatter_sva #(
  parameter int GAP_CYC = 75000
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // reader lines and setup
  input wire logic wg_d0_n,
  input wire logic wg_d1_n,
  input wire logic ms_strobe_n,
  input wire logic ms_track1,
  input wire logic rdr_port1,
  input wire logic [8:0] mask_ins_len,
  // outputs and handshakes
  input wire logic bc_ready,
  input wire logic out_valid,
  input wire logic out_ready,
  input wire logic [7:0] out_data,
  input wire logic out_last,
  input wire logic busy,
  input wire logic err_overlong_q
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  logic [17:0] quiet_q;
  logic wg_seen_q;
  logic ms_seen_q;
  logic done_w;
  assign done_w = out_valid && out_ready && out_last;
  // ----
  // which source owns the stream in flight, idle time since last pulse
  // ----
  always @(posedge clk)
  begin
    if (rst || !wg_d0_n || !wg_d1_n)
      quiet_q <= 18'h00000;
    else if (quiet_q != 18'h3FFFF)
      quiet_q <= quiet_q + 18'h00001;
    wg_seen_q <= !rst && (!wg_d0_n || !wg_d1_n || (wg_seen_q && !done_w));
    ms_seen_q <= !rst && (!ms_strobe_n || (ms_seen_q && !done_w));
  end
  a_reset_quiet: assert property ($fell(rst) |-> !out_valid && !busy && !err_overlong_q && bc_ready)
    else $error("outputs not idle after reset");
  a_hold_output: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data) && $stable(out_last))
    else $error("output changed while stalled");
  a_term_char: assert property (out_valid && out_last |-> out_data == 8'h0D)
    else $error("last character is not the terminator");
  a_port_refuse: assert property (!rdr_port1 |-> bc_ready)
    else $error("barcode stalled on a port that refuses it");
  a_err_pulse: assert property (err_overlong_q |=> !err_overlong_q)
    else $error("overlong flag longer than one cycle");
  a_gap_close: assert property (out_valid && wg_seen_q |-> quiet_q >= GAP_CYC)
    else $error("pulse frame closed before the gap ran out");
  a_wg_digits: assert property (out_valid && !out_last && wg_seen_q && mask_ins_len[2:0] == 3'h0
    |-> out_data inside {[8'h30:8'h39]})
    else $error("pulse frame output is not decimal");
  a_ms_chars: assert property (out_valid && !out_last && ms_seen_q && mask_ins_len[5:3] == 3'h0
    |-> (ms_track1 ? out_data inside {[8'h20:8'h5F]} : out_data[7:4] == 4'h3))
    else $error("stripe character outside its set");
  c_pulse_frame: cover property (done_w && wg_seen_q);
  c_stripe_frame: cover property (done_w && ms_seen_q);
  c_overlong: cover property (err_overlong_q);
endmodule
bind crf_formatter crf_formatter_sva #(.GAP_CYC(GAP_CYC)) i_sva (
  .clk(clk), .rst(rst), .wg_d0_n(wg_d0_n), .wg_d1_n(wg_d1_n), .ms_strobe_n(ms_strobe_n),
  .ms_track1(ms_track1), .rdr_port1(rdr_port1), .mask_ins_len(mask_ins_len), .bc_ready(bc_ready),
  .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data), .out_last(out_last),
  .busy(busy), .err_overlong_q(err_overlong_q)
);
`default_nettype wire

// *** dv/crf_formatter_tb.sv ***
// self-checking bench for the card reader input formatter
// assumes reader model and checker compiled first, hdl/ on the include path
`timescale 1ns/10ps
`default_nettype none
`include "crf_defines.vh"
module crf_formatter_tb;
  logic clk = 1'b0, rst = 1'b1, out_ready = 1'b0, err_seen = 1'b0;
  logic ms_track1 = 1'b0, bc_valid = 1'b0, bc_last = 1'b0, bc_reverse = 1'b0, rdr_port1 = 1'b1;
  logic [7:0] bc_char = 8'h00;
  logic [1:0] bc_kind = 2'h0;
  logic inc_ss = 1'b0, inc_ck = 1'b0, inc_dir = 1'b0, norm_en = 1'b0, pid_en = 1'b0;
  logic [4:0] norm_first = 5'h00, norm_len = 5'h00, pid_off = 5'h00;
  logic [2:0] pre_len = 3'h0, suf_len = 3'h0;
  logic [39:0] pre_str = 40'h0, suf_str = 40'h0;
  logic [95:0] msel = '1;
  logic [17:0] ipos = 18'h0;
  logic [8:0] ilen = 9'h000;
  logic [119:0] istr = 120'h0;
  logic [6:0] fs0 = 7'h00, fs1 = 7'h14, fs2 = 7'h34;
  logic [5:0] fl0 = 6'h14, fl1 = 6'h20, fl2 = 6'h0C;
  logic [3:0] fd0 = 4'h7, fd1 = 4'hA, fd2 = 4'h4;
  wire logic wg_d0_n, wg_d1_n, ms_strobe_n, ms_data_n, bc_ready, out_valid, out_last, busy, err;
  wire logic [7:0] out_data;
  logic [8:0] exp_q[$];
  logic [63:0] r;
  logic [5:0] tv[4] = '{6'h01, 6'h06, 6'h21, 6'h0C};
  int fail_count = 0, n_tests = 0;
  always #20 clk = ~clk;
  crf_reader_model i_rdr (.clk(clk), .wg_d0_n(wg_d0_n), .wg_d1_n(wg_d1_n), .ms_strobe_n(ms_strobe_n),
    .ms_data_n(ms_data_n));
  // gap shortened so frames close quickly; pulse spacing stays below it
  crf_formatter #(.GAP_CYC(200)) i_dut (
    .clk(clk), .rst(rst), .wg_d0_n(wg_d0_n), .wg_d1_n(wg_d1_n), .ms_strobe_n(ms_strobe_n),
    .ms_data_n(ms_data_n), .ms_track1(ms_track1), .bc_valid(bc_valid), .bc_ready(bc_ready),
    .bc_char(bc_char), .bc_kind(bc_kind), .bc_last(bc_last), .bc_reverse(bc_reverse), .rdr_port1(rdr_port1),
    .fld_site_start(fs0), .fld_site_len(fl0), .fld_site_dig(fd0), .fld_badge_start(fs1),
    .fld_badge_len(fl1), .fld_badge_dig(fd1), .fld_issue_start(fs2), .fld_issue_len(fl2),
    .fld_issue_dig(fd2), .bc_incl_startstop(inc_ss), .bc_incl_check(inc_ck), .bc_incl_dir(inc_dir),
    .bc_norm_en(norm_en), .bc_norm_first(norm_first), .bc_norm_len(norm_len),
    .personal_identifier_field_en(pid_en), .personal_identifier_field_off(pid_off), .bc_pre_len(pre_len),
    .bc_pre_str(pre_str), .bc_suf_len(suf_len), .bc_suf_str(suf_str), .mask_sel(msel), .mask_ins_pos(ipos),
    .mask_ins_len(ilen), .mask_ins_str(istr), .out_valid(out_valid), .out_ready(out_ready),
    .out_data(out_data), .out_last(out_last), .busy(busy), .err_overlong_q(err)
  );
  // ----
  // comparison, expectation and closing helpers
  // ----
  task automatic check(input logic [8:0] seen, input logic [8:0] want);
    n_tests++;
    if (seen !== want)
    begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, seen, want);
    end
  endtask
  task automatic results();
    $display("Counts: %0d compared, %0d mismatched", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic put_s(input string s);
    for (int i = 0; i < s.len(); i++)
      exp_q.push_back({1'b0, s[i]});
  endtask
  task automatic put_dec(input logic [63:0] v, input int dig);
    logic [63:0] p;
    p = 64'h1;
    for (int i = 1; i < dig; i++)
      p = p * 10;
    for (int i = 0; i < dig; i++)
    begin
      exp_q.push_back({1'b0, 8'h30 + 8'((v / p) % 10)});
      p = p / 10;
    end
  endtask
  task automatic term();
    exp_q.push_back({1'b1, `CRF_CH_TERM});
  endtask
  // idle well past the gap so any stray character is caught
  task automatic settle(input string name);
    int t;
    t = 0;
    while (exp_q.size() != 0 && t < 3000)
    begin
      @(posedge clk);
      t++;
    end
    repeat (300) @(posedge clk);
    check(9'(exp_q.size()), 9'h000);
    $display("Test %s finished", name);
  endtask
  task automatic bc_put(input logic [1:0] k, input logic [7:0] c, input logic l);
    bc_valid <= 1'b1;
    bc_kind <= k;
    bc_char <= c;
    bc_last <= l;
    do
      @(posedge clk);
    while (bc_ready !== 1'b1);
    if (l)
      bc_valid <= 1'b0;
  endtask
  task automatic bc_sym(input string d, input logic wrap);
    if (wrap)
      bc_put(`CRF_BC_STARTSTOP, 8'h2A, 1'b0);
    for (int i = 0; i < d.len(); i++)
      bc_put(`CRF_BC_DATA, d[i], !wrap && i == d.len() - 1);
    if (wrap)
    begin
      bc_put(`CRF_BC_CHECK, 8'h37, 1'b0);
      bc_put(`CRF_BC_STARTSTOP, 8'h2A, 1'b1);
    end
  endtask
  // ----
  // output watcher with random stalls
  // ----
  always @(posedge clk)
  begin
    if (err === 1'b1)
      err_seen <= 1'b1;
    if (!rst && out_valid === 1'b1 && out_ready === 1'b1)
    begin
      if (exp_q.size() == 0)
        check({out_last, out_data}, ~{out_last, out_data});
      else
        check({out_last, out_data}, exp_q.pop_front());
    end
    out_ready <= ($urandom % 4) != 0;
  end
  initial
  begin
    repeat (96000) @(posedge clk);
    fail_count++;
    results();
  end
  initial
  begin
    void'($urandom(77));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    r = 64'($urandom);
    put_dec(r[23:16], 3);
    put_dec(r[15:0], 5);
    term();
    i_rdr.wg_frame(64'h1, 1, 300, 60);
    i_rdr.wg_frame({38'h0, r[23:0], 1'b1}, 26, 375, 30);
    settle("pulse fast");
    r = 64'($urandom);
    msel[31:0] <= 32'hFFFFFFFE;
    ipos[5:0] <= 6'h03;
    ilen[2:0] <= 3'h2;
    istr[39:0] <= 40'h0000004241;
    put_dec(r[23:16], 3);
    put_dec(r[15:0], 5);
    exp_q.insert(3, 9'h041);
    exp_q.insert(4, 9'h042);
    exp_q.delete(0);
    term();
    i_rdr.wg_frame({38'h0, r[23:0], 1'b1}, 26, 500, 150);
    settle("pulse slow masked");
    msel <= '1;
    ilen <= 9'h000;
    r = {$urandom, $urandom};
    put_dec(r[63:44], 7);
    put_dec(r[43:12], 10);
    put_dec(r[11:0], 4);
    term();
    i_rdr.wg_frame(r, 64, 375, 30);
    settle("pulse 64");
    for (int t = 0; t < 2; t++)
    begin
      ms_track1 <= t[0];
      for (int i = 0; i < 2; i++)
        exp_q.push_back({1'b0, (t ? 8'h20 : 8'h30) + {2'h0, tv[2 * t + i]}});
      term();
      i_rdr.ms_bits(7'h00, 1);
      for (int i = 0; i < 2; i++)
        i_rdr.ms_bits(t ? {~^tv[2 + i], tv[2 + i]} : {2'h0, ~^tv[i][3:0], tv[i][3:0]}, t ? 7 : 5);
      settle("stripe");
    end
    inc_ss <= 1'b1;
    inc_ck <= 1'b1;
    inc_dir <= 1'b1;
    bc_reverse <= 1'b1;
    pre_len <= 3'h2;
    pre_str <= 40'h0000005150;
    suf_len <= 3'h5;
    suf_str <= "YXWVU";
    msel[95:64] <= 32'hFFFFFFFD;
    ilen[8:6] <= 3'h1;
    istr[119:80] <= 40'h000000005A;
    put_s("PQZ*2347*RUVWXY");
    term();
    bc_sym("1234", 1'b1);
    settle("barcode affixes");
    {inc_ss, inc_ck, inc_dir, bc_reverse} <= 4'h0;
    {pre_len, suf_len, ilen} <= 15'h0000;
    msel <= '1;
    norm_en <= 1'b1;
    norm_first <= 5'h02;
    norm_len <= 5'h03;
    put_s("CDE");
    term();
    bc_sym("ABCDEFGHIJKLMNOPQRSTUV", 1'b0);
    settle("barcode window");
    pid_en <= 1'b1;
    pid_off <= 5'h01;
    put_s("123456789");
    term();
    bc_sym("012345678901", 1'b1);
    settle("barcode id");
    err_seen = 1'b0;
    bc_sym("ABCDEFGHIJKLMNOPQRSTUVW", 1'b0);
    settle("barcode overlong");
    check({8'h00, err_seen}, 9'h001);
    rdr_port1 <= 1'b0;
    bc_sym("12", 1'b0);
    settle("barcode refused");
    results();
  end
endmodule
`default_nettype wire

// *** dv/crf_reader_model.sv ***
// card reader model: pulse-data and clock-and-data lines
// assumes its tasks are called just after a rising edge of clk
`timescale 1ns/10ps
`default_nettype none
module crf_reader_model (
  // clock
  input wire logic clk,
  // reader lines, active low
  output logic wg_d0_n,
  output logic wg_d1_n,
  output logic ms_strobe_n,
  output logic ms_data_n
);
  // open-collector lines sit at the pull-up level when not driven
  initial
  begin
    wg_d0_n = 1'b1;
    wg_d1_n = 1'b1;
    ms_strobe_n = 1'b1;
    ms_data_n = 1'b1;
  end
  // ----
  // pulse frame, first bit sent is bits[n-1]
  // ----
  task automatic wg_frame(input logic [63:0] bits, input int n, input int wid, input int gap);
    for (int k = n - 1; k >= 0; k--)
    begin
      if (bits[k])
        wg_d1_n <= 1'b0;
      else
        wg_d0_n <= 1'b0;
      repeat (wid) @(posedge clk);
      wg_d0_n <= 1'b1;
      wg_d1_n <= 1'b1;
      repeat (gap) @(posedge clk);
    end
  endtask
  // ----
  // stripe bits, least significant first
  // ----
  task automatic ms_bits(input logic [6:0] v, input int n);
    for (int k = 0; k < n; k++)
    begin
      ms_data_n <= ~v[k];
      @(posedge clk);
      ms_strobe_n <= 1'b0;
      repeat (1250) @(posedge clk);
      ms_strobe_n <= 1'b1;
      // data invalid outside the strobe: show the opposite level
      ms_data_n <= v[k];
      repeat (40) @(posedge clk);
    end
  endtask
endmodule
`default_nettype wire

// *** hdl/crf_defines.vh ***
// constants for the card reader input formatter
// assumes a single 25 MHz clock and synchronous reset
`ifndef CRF_DEFINES_VH
`define CRF_DEFINES_VH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CRF_CLK_KHZ 25000
`define CRF_WG_MIN_PULSE_NS 15000
`define CRF_WG_MIN_PULSE_CYC ((`CRF_WG_MIN_PULSE_NS * `CRF_CLK_KHZ + 999999) / 1000000)
`define CRF_MS_MIN_STROBE_NS 50000
`define CRF_MS_MIN_STROBE_CYC ((`CRF_MS_MIN_STROBE_NS * `CRF_CLK_KHZ + 999999) / 1000000)
`define CRF_MAX_GAP_US 3000
`define CRF_MAX_GAP_CYC ((`CRF_MAX_GAP_US * `CRF_CLK_KHZ) / 1000)

// ----------------------------------------------------------------
// sizes and default pulse format
// ----------------------------------------------------------------
`define CRF_MAX_BITS 64
`define CRF_BUF_DEPTH 32
`define CRF_FIFO_DEPTH 8
`define CRF_BC_MAX_CHARS 22
`define CRF_AFFIX_MAX 5
`define CRF_PDI_DIGITS 6'h09
`define CRF_STD_BITS 7'h1A
`define CRF_STD_SITE_START 7'h01
`define CRF_STD_SITE_LEN 6'h08
`define CRF_STD_SITE_DIG 4'h3
`define CRF_STD_BADGE_START 7'h09
`define CRF_STD_BADGE_LEN 6'h10
`define CRF_STD_BADGE_DIG 4'h5

// ----------------------------------------------------------------
// input types, barcode element kinds, characters
// ----------------------------------------------------------------
`define CRF_TYPE_PROX 2'h0
`define CRF_TYPE_MAG 2'h1
`define CRF_TYPE_BAR 2'h2
`define CRF_BC_DATA 2'h0
`define CRF_BC_STARTSTOP 2'h1
`define CRF_BC_CHECK 2'h2
`define CRF_CH_ZERO 8'h30
`define CRF_CH_TRK1_BASE 8'h20
`define CRF_CH_FWD 8'h46
`define CRF_CH_REV 8'h52
`define CRF_CH_TERM 8'h0D

`endif

// *** hdl/crf_formatter.v ***
// card reader input formatter: pulse, clock-and-data and barcode to characters
// assumes reader lines already synchronous to clk; barcode arrives as symbols
// Operation
// - barcode gets prefix and suffix, five characters
// - affixes work alongside masking insert and delete
// - optional start/stop, check digits, direction indicator
// - personal id mode keeps nine digits
// - normalization limits decoding to selected span
// - mask inserts configured sequence at configured position
// - mask keeps only selected characters
// - separate mask set per input type
// - pulse rate detected automatically, no setting
// - pulse frames accepted up to 64 bits
// - stripe accepts track one, two, three
// - barcode only on first reader port
// - barcode symbol limited to 22 characters
// - 26-bit default: 3-digit site, 5-digit badge
// - fields joined as site, badge, issue
`timescale 1ns/10ps
`default_nettype none
`include "crf_defines.vh"

module crf_fifo #(
  parameter W = 9,
  parameter D = 8,
  parameter AW = 3
) (
  // clock and reset
  input wire clk,
  input wire rst,
  // fill side
  input wire in_valid,
  output wire in_ready,
  input wire [W-1:0] in_data,
  // drain side
  output wire out_valid,
  input wire out_ready,
  output wire [W-1:0] out_data
);
  reg [W-1:0] mem [0:D-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  reg [AW:0] cnt_q;
  wire push;
  wire pop;

  assign in_ready = (cnt_q != D);
  assign out_valid = (cnt_q != 0);
  assign out_data = mem[rd_q];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always @(posedge clk)
  begin
    if (rst)
    begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
      begin
        mem[wr_q] <= in_data;
        wr_q <= wr_q + 1'b1;
      end
      if (pop)
        rd_q <= rd_q + 1'b1;
      if (push & ~pop)
        cnt_q <= cnt_q + 1'b1;
      else if (pop & ~push)
        cnt_q <= cnt_q - 1'b1;
    end
  end
endmodule

module crf_formatter #(
  parameter GAP_CYC = `CRF_MAX_GAP_CYC
) (
  // clock and reset
  input wire clk,
  input wire rst,
  // pulse-data reader lines, active low
  input wire wg_d0_n,
  input wire wg_d1_n,
  // clock-and-data reader lines, active low, and track one select
  input wire ms_strobe_n,
  input wire ms_data_n,
  input wire ms_track1,
  // decoded barcode symbols
  input wire bc_valid,
  output wire bc_ready,
  input wire [7:0] bc_char,
  input wire [1:0] bc_kind,
  input wire bc_last,
  input wire bc_reverse,
  // configuration
  input wire rdr_port1,
  input wire [6:0] fld_site_start,
  input wire [5:0] fld_site_len,
  input wire [3:0] fld_site_dig,
  input wire [6:0] fld_badge_start,
  input wire [5:0] fld_badge_len,
  input wire [3:0] fld_badge_dig,
  input wire [6:0] fld_issue_start,
  input wire [5:0] fld_issue_len,
  input wire [3:0] fld_issue_dig,
  input wire bc_incl_startstop,
  input wire bc_incl_check,
  input wire bc_incl_dir,
  input wire bc_norm_en,
  input wire [4:0] bc_norm_first,
  input wire [4:0] bc_norm_len,
  input wire personal_identifier_field_en,
  input wire [4:0] personal_identifier_field_off,
  input wire [2:0] bc_pre_len,
  input wire [39:0] bc_pre_str,
  input wire [2:0] bc_suf_len,
  input wire [39:0] bc_suf_str,
  input wire [95:0] mask_sel,
  input wire [17:0] mask_ins_pos,
  input wire [8:0] mask_ins_len,
  input wire [119:0] mask_ins_str,
  // formatted character stream, last marks terminator
  output wire out_valid,
  input wire out_ready,
  output wire [7:0] out_data,
  output wire out_last,
  // status
  output wire busy,
  output reg err_overlong_q
);
  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  localparam S_IDLE = 3'h0, S_BCOL = 3'h1, S_WFLD = 3'h2, S_WDEC = 3'h3;
  localparam S_PRE = 3'h4, S_DAT = 3'h5, S_INS = 3'h6, S_SUF = 3'h7;

  function [7:0] pick_chr;
    input [39:0] str;
    input [2:0] i;
    begin
      pick_chr = str[i*8 +: 8];
    end
  endfunction

  reg [7:0] buf_mem [0:`CRF_BUF_DEPTH-1];
  reg [2:0] st_q;
  reg [1:0] type_q;
  reg [5:0] len_q;
  reg [5:0] idx_q;
  reg [2:0] sub_q;
  reg ins_done_q;
  reg term_q;
  // pulse receiver
  reg [10:0] wg_cnt_q;
  reg wg_bit_q;
  reg [63:0] wg_sr_q;
  reg [6:0] wg_n_q;
  reg wg_act_q;
  // stripe receiver
  reg [10:0] ms_cnt_q;
  reg ms_act_q;
  reg ms_sync_q;
  reg [6:0] ms_ch_q;
  reg [2:0] ms_bc_q;
  reg [16:0] gap_q;
  // barcode
  reg [4:0] bc_total_q;
  reg [4:0] bc_dcnt_q;
  // decimal conversion
  reg [1:0] fld_q;
  reg [31:0] val_q;
  reg [3:0] dig_q;
  reg [3:0] digs_q;
  reg [5:0] base_q;

  wire wg_low = ~wg_d0_n | ~wg_d1_n;
  wire wg_min = (wg_cnt_q >= `CRF_WG_MIN_PULSE_CYC);
  wire wg_take = ~wg_low & wg_min;
  wire ms_take = ~ms_strobe_n & (ms_cnt_q == `CRF_MS_MIN_STROBE_CYC - 1);
  wire ms_bit = ~ms_data_n;
  wire [2:0] ms_cw = ms_track1 ? 3'h7 : 3'h5;
  wire gap_end = (gap_q == GAP_CYC - 1);
  wire collect = (st_q == S_IDLE);
  wire fin_wg = gap_end & wg_act_q;
  wire fin_ms = gap_end & ms_act_q;
  wire [31:0] dec_rem = val_q % 32'd10;

  // ----------------------------------------------------------------
  // field select and mask set for current type
  // ----------------------------------------------------------------
  wire std26 = (wg_n_q == `CRF_STD_BITS);
  reg [6:0] f_start;
  reg [5:0] f_len;
  reg [3:0] f_dig;
  always @*
  begin
    f_start = fld_issue_start;
    f_len = fld_issue_len;
    f_dig = fld_issue_dig;
    case (fld_q)
      2'h0:
      begin
        f_start = std26 ? `CRF_STD_SITE_START : fld_site_start;
        f_len = std26 ? `CRF_STD_SITE_LEN : fld_site_len;
        f_dig = std26 ? `CRF_STD_SITE_DIG : fld_site_dig;
      end
      2'h1:
      begin
        f_start = std26 ? `CRF_STD_BADGE_START : fld_badge_start;
        f_len = std26 ? `CRF_STD_BADGE_LEN : fld_badge_len;
        f_dig = std26 ? `CRF_STD_BADGE_DIG : fld_badge_dig;
      end
      default:
      begin
        f_dig = std26 ? 4'h0 : fld_issue_dig;
      end
    endcase
  end
  wire [7:0] f_end = {1'b0, f_start} + {2'b00, f_len};
  wire [6:0] f_shift = wg_n_q - f_end[6:0];
  wire [63:0] f_raw = (wg_sr_q >> f_shift) & ((64'h1 << f_len) - 64'h1);
  wire [31:0] f_val = (f_end > {1'b0, wg_n_q}) ? 32'h0 : f_raw[31:0];

  wire [31:0] m_sel = mask_sel[type_q*32 +: 32];
  wire [5:0] m_pos = mask_ins_pos[type_q*6 +: 6];
  wire [2:0] m_len = mask_ins_len[type_q*3 +: 3];
  wire [39:0] m_str = mask_ins_str[type_q*40 +: 40];

  // barcode element filter
  wire bc_is_data = (bc_kind == `CRF_BC_DATA);
  wire [5:0] norm_hi = {1'b0, bc_norm_first} + {1'b0, bc_norm_len};
  wire [5:0] pdi_hi = {1'b0, personal_identifier_field_off} + `CRF_PDI_DIGITS;
  wire bc_keep_data = personal_identifier_field_en ?
    (bc_dcnt_q >= personal_identifier_field_off && {1'b0, bc_dcnt_q} < pdi_hi) :
    (~bc_norm_en | (bc_dcnt_q >= bc_norm_first && {1'b0, bc_dcnt_q} < norm_hi));
  wire bc_keep = bc_is_data ? bc_keep_data :
    (bc_kind == `CRF_BC_STARTSTOP) ? bc_incl_startstop : bc_incl_check;
  wire bc_open = rdr_port1 & ((st_q == S_BCOL) | (collect & ~wg_act_q & ~ms_act_q));
  assign bc_ready = bc_open | ~rdr_port1;
  wire bc_fire = bc_valid & bc_open;
  wire bc_over = (bc_total_q == `CRF_BC_MAX_CHARS);

  // ----------------------------------------------------------------
  // emitter into the fifo
  // ----------------------------------------------------------------
  reg push;
  reg [8:0] push_d;
  wire f_ready;
  always @*
  begin
    push = 1'b0;
    push_d = 9'h0;
    case (st_q)
      S_PRE:
      begin
        push = (sub_q < bc_pre_len);
        push_d = {1'b0, pick_chr(bc_pre_str, sub_q)};
      end
      S_DAT:
      begin
        push = ~(~ins_done_q & idx_q == m_pos & m_len != 3'h0) & idx_q != len_q & m_sel[idx_q[4:0]];
        push_d = {1'b0, buf_mem[idx_q[4:0]]};
      end
      S_INS:
      begin
        push = 1'b1;
        push_d = {1'b0, pick_chr(m_str, sub_q)};
      end
      S_SUF:
      begin
        push = 1'b1;
        push_d = term_q ? {1'b1, `CRF_CH_TERM} : {1'b0, pick_chr(bc_suf_str, sub_q)};
      end
      default:
      begin
        push = 1'b0;
      end
    endcase
  end

  crf_fifo #(.W(9), .D(`CRF_FIFO_DEPTH), .AW(3)) u_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(push),
    .in_ready(f_ready),
    .in_data(push_d),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_data({out_last, out_data})
  );

  assign busy = (st_q != S_IDLE) | wg_act_q | ms_act_q;
  wire stall = push & ~f_ready;

  // ----------------------------------------------------------------
  // receivers and sequencer
  // ----------------------------------------------------------------
  always @(posedge clk)
  begin
    if (rst)
    begin
      st_q <= S_IDLE;
      type_q <= `CRF_TYPE_PROX;
      len_q <= 6'h0;
      idx_q <= 6'h0;
      sub_q <= 3'h0;
      ins_done_q <= 1'b0;
      term_q <= 1'b0;
      wg_cnt_q <= 11'h0;
      wg_bit_q <= 1'b0;
      wg_sr_q <= 64'h0;
      wg_n_q <= 7'h0;
      wg_act_q <= 1'b0;
      ms_cnt_q <= 11'h0;
      ms_act_q <= 1'b0;
      ms_sync_q <= 1'b0;
      ms_ch_q <= 7'h0;
      ms_bc_q <= 3'h0;
      gap_q <= 17'h0;
      bc_total_q <= 5'h0;
      bc_dcnt_q <= 5'h0;
      fld_q <= 2'h0;
      val_q <= 32'h0;
      dig_q <= 4'h0;
      digs_q <= 4'h0;
      base_q <= 6'h0;
      err_overlong_q <= 1'b0;
    end
    else
    begin
      err_overlong_q <= 1'b0;
      // width measured per pulse, so any reader rate is accepted
      wg_cnt_q <= wg_low ? (wg_min ? wg_cnt_q : wg_cnt_q + 1'b1) : 11'h0;
      if (wg_low)
        wg_bit_q <= ~wg_d1_n & wg_d0_n;
      // saturate one past the sample point so each strobe is taken once
      ms_cnt_q <= ~ms_strobe_n ? (ms_cnt_q == `CRF_MS_MIN_STROBE_CYC ? ms_cnt_q : ms_cnt_q + 1'b1) : 11'h0;
      if (wg_take | ms_take | wg_low | ~ms_strobe_n)
        gap_q <= 17'h0;
      else if (wg_act_q | ms_act_q)
        gap_q <= gap_q + 1'b1; // frame closes after the longest gap
      if (wg_take & ~ms_act_q & collect)
      begin
        wg_act_q <= 1'b1;
        wg_sr_q <= {wg_sr_q[62:0], wg_bit_q};
        if (~wg_act_q)
          wg_n_q <= 7'h01;
        else if (wg_n_q != `CRF_MAX_BITS)
          wg_n_q <= wg_n_q + 1'b1;
      end
      // stripe: leading zeros skipped until the first one
      if (ms_take & ~wg_act_q & collect & (ms_sync_q | ms_bit))
      begin
        ms_act_q <= 1'b1;
        ms_sync_q <= 1'b1;
        ms_ch_q[ms_bc_q] <= ms_bit;
        if (ms_bc_q == ms_cw - 1'b1)
        begin
          ms_bc_q <= 3'h0;
          if (len_q != `CRF_BUF_DEPTH)
          begin
            buf_mem[len_q[4:0]] <= ms_track1 ? `CRF_CH_TRK1_BASE + {2'b00, ms_ch_q[5:0]}
              : `CRF_CH_ZERO + {4'h0, ms_ch_q[3:0]};
            len_q <= len_q + 1'b1;
          end
        end
        else
          ms_bc_q <= ms_bc_q + 1'b1;
      end
      case (st_q)
        S_IDLE:
        begin
          bc_total_q <= 5'h0;
          bc_dcnt_q <= 5'h0;
          idx_q <= 6'h0;
          sub_q <= 3'h0;
          ins_done_q <= 1'b0;
          term_q <= 1'b0;
          if (fin_wg)
          begin
            wg_act_q <= 1'b0; // bit count now fixes the format
            type_q <= `CRF_TYPE_PROX;
            fld_q <= 2'h0;
            len_q <= 6'h0;
            st_q <= S_WFLD;
          end
          else if (fin_ms)
          begin
            ms_act_q <= 1'b0;
            ms_sync_q <= 1'b0;
            ms_bc_q <= 3'h0;
            type_q <= `CRF_TYPE_MAG;
            st_q <= S_PRE;
          end
          else if (bc_fire)
          begin
            type_q <= `CRF_TYPE_BAR;
            st_q <= S_BCOL;
          end
        end
        S_BCOL:
        begin
          // elements taken below, so the idle edge keeps the first one
        end
        S_WFLD:
        begin
          if (fld_q == 2'h3)
            st_q <= S_PRE;
          else if (f_dig == 4'h0)
            fld_q <= fld_q + 1'b1;
          else
          begin
            val_q <= f_val;
            digs_q <= f_dig;
            dig_q <= 4'h0;
            base_q <= len_q;
            st_q <= S_WDEC;
          end
        end
        S_WDEC:
        begin
          // digits fill right to left, fields land in order
          buf_mem[base_q[4:0] + {1'b0, digs_q} - {1'b0, dig_q} - 5'h1] <= `CRF_CH_ZERO + dec_rem[7:0];
          val_q <= val_q / 32'd10;
          dig_q <= dig_q + 1'b1;
          if (dig_q == digs_q - 1'b1)
          begin
            len_q <= len_q + {2'b00, digs_q};
            fld_q <= fld_q + 1'b1;
            st_q <= S_WFLD;
          end
        end
        S_PRE:
        begin
          if (type_q != `CRF_TYPE_BAR || sub_q >= bc_pre_len)
          begin
            sub_q <= 3'h0;
            st_q <= S_DAT;
          end
          else if (~stall)
            sub_q <= sub_q + 1'b1;
        end
        S_DAT:
        begin
          if (~ins_done_q & idx_q == m_pos & m_len != 3'h0)
            st_q <= S_INS;
          else if (idx_q == len_q)
          begin
            sub_q <= 3'h0;
            term_q <= (type_q != `CRF_TYPE_BAR) | (bc_suf_len == 3'h0);
            st_q <= S_SUF;
          end
          else if (~stall)
            idx_q <= idx_q + 1'b1;
        end
        S_INS:
        begin
          if (~stall)
          begin
            sub_q <= sub_q + 1'b1;
            if (sub_q == m_len - 1'b1)
            begin
              sub_q <= 3'h0;
              ins_done_q <= 1'b1;
              st_q <= S_DAT;
            end
          end
        end
        default:
        begin
          if (~stall)
          begin
            if (term_q)
            begin
              len_q <= 6'h0;
              st_q <= S_IDLE;
            end
            else if (sub_q == bc_suf_len - 1'b1)
              term_q <= 1'b1;
            else
              sub_q <= sub_q + 1'b1;
          end
        end
      endcase
      if (bc_fire)
      begin
        if (bc_over)
          bc_total_q <= bc_total_q;
        else
          bc_total_q <= bc_total_q + 1'b1;
        if (bc_is_data)
          bc_dcnt_q <= bc_dcnt_q + 1'b1;
        if (bc_keep & ~bc_over)
        begin
          buf_mem[len_q[4:0]] <= bc_char;
          len_q <= len_q + 1'b1;
        end
        if (bc_last)
        begin
          if (bc_over)
          begin
            err_overlong_q <= 1'b1; // overlong symbol is dropped whole
            len_q <= 6'h0;
            st_q <= S_IDLE;
          end
          else
          begin
            if (bc_incl_dir)
            begin
              buf_mem[len_q[4:0] + (bc_keep ? 5'h1 : 5'h0)] <= bc_reverse ? `CRF_CH_REV : `CRF_CH_FWD;
              len_q <= len_q + (bc_keep ? 6'h2 : 6'h1);
            end
            st_q <= S_PRE;
          end
        end
      end
    end
  end
endmodule
`default_nettype wire
